// >>> src/pcc_pkg.sv
// pcc_pkg: register indices, field layout, reset values, timing constants
// and shared types of the clock ratio control block.
// assumes the 50 MHz pclk domain; used by package::name, never imported.
package pcc_pkg;

  // register indices (word index; byte address is four times the index)
  localparam logic [15:0] IDX_HS_PRESCALE  = 16'h701A;
  localparam logic [15:0] IDX_LS_PRESCALE  = 16'h701B;
  localparam logic [15:0] IDX_CLK_GATE     = 16'h701C;
  localparam logic [15:0] IDX_LOW_POWER_0  = 16'h701E;
  localparam logic [15:0] IDX_LOW_POWER_1  = 16'h701F;
  localparam logic [15:0] IDX_PLL_RATIO    = 16'h7021;
  localparam logic [15:0] IDX_SYS_STATUS   = 16'h7022;
  localparam logic [15:0] IDX_WD_COUNT     = 16'h7023;
  localparam logic [15:0] IDX_WD_KEY       = 16'h7025;
  localparam logic [15:0] IDX_WD_CONTROL   = 16'h7029;
  localparam logic [15:0] IDX_ACCESS_UNLK  = 16'h7030;

  // field layout
  localparam int RATIO_W        = 4;   // ratio field, bits 3:0
  localparam int WD_CNT_W       = 8;   // watchdog up counter width
  localparam int WD_EN_BIT      = 0;   // watchdog_control enable bit
  localparam int UNLOCK_BIT     = 0;   // access unlock bit
  localparam int ST_PLL_STABLE  = 0;   // status: pll has settled
  localparam int ST_CLK_LOST    = 1;   // status: input clock missing
  localparam int ST_LIMP        = 2;   // status: running on limp clock
  localparam int ST_PLL_OFF     = 3;   // status: pll disabled by strap

  // values after reset, plus bypass code and highest valid ratio
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [3:0]  RATIO_RESET     = 4'h0;
  localparam logic [3:0]  RATIO_BYPASS    = 4'h0;
  localparam logic [3:0]  RATIO_MAX_VALID = 4'hA;

  // timing: input clock counted as lost after this long with no edge
  localparam int CLK_PERIOD_NS  = 20;
  localparam int LOSS_TIME_NS   = 1000;
  localparam int LOSS_CYCLES    = LOSS_TIME_NS / CLK_PERIOD_NS;
  localparam int LOSS_CNT_W     = 8;
  // pll settling time in input clock cycles
  localparam int PLL_LOCK_CYCLES = 131072;
  localparam int LOCK_CNT_W      = 18;
  // pclk edges after reset release before the strap is caught
  localparam logic [1:0] STRAP_CATCH = 2'h2;
  localparam logic [1:0] STRAP_DONE  = 2'h3;

  // clocking modes presented to the clock tree
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,  // cpu clock straight from input clock
    MODE_BYPASS   = 2'b01,  // input clock divided by two
    MODE_ENABLED  = 2'b10,  // input clock times n divided by two
    MODE_LIMP     = 2'b11   // pll free-running limp clock
  } pcc_mode_t;

  // clock tree control bundle
  typedef struct packed {
    pcc_mode_t          mode;  // selected path
    logic [RATIO_W-1:0] mult;  // pll multiplier n
    logic               div2;  // divide-by-two stage in use
    logic               pll_on; // pll powered
  } pcc_clk_ctrl_t;

endpackage : pcc_pkg

// >>> src/pcc_sync.sv
// pcc_sync: two flip-flop synchroniser for W independent levels.
// assumes inputs are slow levels; multi-bit values are not coherent.
`timescale 1ns/1ns
module pcc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,     // destination clock
  input  wire logic         presetn,  // async reset, active low
  input  wire logic [W-1:0] d,        // asynchronous levels
  output logic      [W-1:0] q         // synchronised levels
);

  logic [W-1:0] stage1;  // metastable stage, read only by q

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : pcc_sync

// >>> src/pcc_loss_det.sv
// pcc_loss_det: finds edges of the sampled input clock and flags its loss.
// assumes clk_level already synchronised to pclk; the input clock must be
// well under half of pclk for edges to be seen.
`timescale 1ns/1ns
module pcc_loss_det (
  input  wire logic pclk,       // system clock
  input  wire logic presetn,    // async reset, active low
  input  wire logic clk_level,  // synchronised input clock level
  output logic      clk_rise,   // one-cycle pulse per input clock rise
  output logic      clk_lost    // level, no edge for the loss time
);

  logic                           prev;  // last sampled level
  logic [pcc_pkg::LOSS_CNT_W-1:0] idle;  // cycles since last edge

  assign clk_rise = clk_level & ~prev;

  // edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev <= 1'b0;
    else          prev <= clk_level;
  end

  // idle counter saturates; any edge restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle     <= '0;
      clk_lost <= 1'b0;
    end else if (clk_level != prev) begin
      idle     <= '0;
      clk_lost <= 1'b0;
    end else if (idle ==
                 pcc_pkg::LOSS_CNT_W'(pcc_pkg::LOSS_CYCLES - 1)) begin
      clk_lost <= 1'b1;  // held until edges return
    end else begin
      idle <= idle + 1'b1;
    end
  end

endmodule : pcc_loss_det

// >>> src/pcc_ctrl.sv
// pcc_ctrl: clock ratio control, protected clock map and watchdog stall.
// assumes an APB master on pclk; presetn is the external reset pin, the
// debugger reset and all pins arrive asynchronously.
//
// What this block does
// - clock map writable only while unlocked
// - only external reset pin resets ratio
// - ratio bits 3:0, upper bits read zero
// - zero bypasses, 1-10 multiply, above reserved
// - strap low at reset: cpu takes input
// - power-up default is bypass, half input
// - ratio 1-10 enables pll, output halved
// - lost input clock with ratio: limp clock
// - watchdog count frozen while in limp
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module pcc_ctrl #(
  parameter int LOCK_CYCLES = pcc_pkg::PLL_LOCK_CYCLES  // settle time
) (
  input  wire logic                  pclk,        // 50 MHz system clock
  input  wire logic                  presetn,     // external reset pin
  input  wire logic                  psel,        // apb select
  input  wire logic                  penable,     // apb access phase
  input  wire logic                  pwrite,      // apb direction
  input  wire logic [17:0]           paddr,       // apb byte address
  input  wire logic [31:0]           pwdata,      // apb write data
  output logic      [31:0]           prdata,      // apb read data
  output logic                       pready,      // apb ready
  output logic                       pslverr,     // apb error
  input  wire logic                  debug_reset_n, // debugger reset
  input  wire logic                  pll_disable_pin, // strap, low=off
  input  wire logic                  input_clock, // crystal/osc clock
  output pcc_pkg::pcc_clk_ctrl_t     clk_ctrl,    // clock tree control
  output logic [15:0]                hs_prescale, // high speed prescale
  output logic [15:0]                ls_prescale, // low speed prescale
  output logic [15:0]                clk_gate,    // peripheral gates
  output logic [15:0]                low_power_0, // low power control 0
  output logic [15:0]                low_power_1, // low power control 1
  output logic                       watchdog_wake_event // count wrap
);

  // synchronised pins
  logic        dbg_rst_s;     // debugger reset asserted, synchronised
  logic        strap_s;       // pll disable strap, synchronised
  logic        clk_s;         // input clock level, synchronised
  logic        clk_rise;      // input clock rising edge pulse
  logic        clk_lost;      // input clock absent

  // register state
  logic [3:0]  pll_ratio_control;  // ratio field
  logic [15:0] wd_key;             // watchdog key storage
  logic [15:0] wd_control;         // watchdog control
  logic [pcc_pkg::WD_CNT_W-1:0] wd_count;  // watchdog up counter
  logic        unlocked;           // protected access open
  logic        pll_off;            // strap caught at reset release
  logic [1:0]  boot_cnt;           // edges since reset release
  logic [pcc_pkg::LOCK_CNT_W-1:0] lock_cnt; // pll settle counter
  logic        pll_stable;         // settle counter has run out

  // bus decode
  logic        in_map;        // address word aligned, low bits zero
  logic [15:0] idx;           // word index
  logic        wr_en;         // write commits this edge
  logic        prot_wr;       // write to a protected register
  logic        hit;           // index names a register
  logic [15:0] rd_word;       // selected read value
  logic        ratio_valid;   // ratio within 1..10
  logic        limp;          // limp clock active
  logic        wd_run;        // watchdog counts this edge

  // pins from outside the domain pass two flops; the debugger reset is
  // carried inverted so the flops' reset state reads as not asserted,
  // else the registers the debugger reset clears would be cleared for two edges after release
  pcc_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({~debug_reset_n, pll_disable_pin, input_clock}),
    .q       ({dbg_rst_s, strap_s, clk_s})
  );

  // input clock activity watch
  pcc_loss_det u_loss (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_level (clk_s),
    .clk_rise  (clk_rise),
    .clk_lost  (clk_lost)
  );

  // --------------------------------------------------------------
  // apb decode; one access cycle, pready high throughout access
  // --------------------------------------------------------------
  assign idx    = paddr[17:2];
  assign in_map = (paddr[1:0] == 2'h0);
  assign wr_en  = psel & penable & pwrite;
  assign pready = psel & penable;

  // known register indices
  always_comb begin
    case (idx)
      pcc_pkg::IDX_HS_PRESCALE, pcc_pkg::IDX_LS_PRESCALE,
      pcc_pkg::IDX_CLK_GATE,    pcc_pkg::IDX_LOW_POWER_0,
      pcc_pkg::IDX_LOW_POWER_1, pcc_pkg::IDX_PLL_RATIO,
      pcc_pkg::IDX_SYS_STATUS,  pcc_pkg::IDX_WD_COUNT,
      pcc_pkg::IDX_WD_KEY,      pcc_pkg::IDX_WD_CONTROL,
      pcc_pkg::IDX_ACCESS_UNLK: hit = in_map;
      default:                  hit = 1'b0;
    endcase
  end

  // every mapped register except the unlock itself is protected
  assign prot_wr = wr_en & hit & (idx != pcc_pkg::IDX_ACCESS_UNLK)
                   & unlocked;

  // unmapped accesses answer with an error, reads return zero
  assign pslverr = psel & penable & ~hit;

  // read mux, narrow registers zero-extended
  always_comb begin
    case (idx)
      pcc_pkg::IDX_HS_PRESCALE: rd_word = hs_prescale;
      pcc_pkg::IDX_LS_PRESCALE: rd_word = ls_prescale;
      pcc_pkg::IDX_CLK_GATE:    rd_word = clk_gate;
      pcc_pkg::IDX_LOW_POWER_0: rd_word = low_power_0;
      pcc_pkg::IDX_LOW_POWER_1: rd_word = low_power_1;
      pcc_pkg::IDX_PLL_RATIO:   rd_word = {12'h000, pll_ratio_control};
      pcc_pkg::IDX_SYS_STATUS: begin
        rd_word = 16'h0000;
        rd_word[pcc_pkg::ST_PLL_STABLE] = pll_stable;
        rd_word[pcc_pkg::ST_CLK_LOST]   = clk_lost;
        rd_word[pcc_pkg::ST_LIMP]       = limp;
        rd_word[pcc_pkg::ST_PLL_OFF]    = pll_off;
      end
      pcc_pkg::IDX_WD_COUNT:    rd_word = {8'h00, wd_count};
      pcc_pkg::IDX_WD_KEY:      rd_word = wd_key;
      pcc_pkg::IDX_WD_CONTROL:  rd_word = wd_control;
      pcc_pkg::IDX_ACCESS_UNLK: rd_word = {15'h0000, unlocked};
      default:                  rd_word = 16'h0000;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      if (hit & ~pwrite) prdata <= {16'h0000, rd_word};
      else               prdata <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------
  // protection gate; cleared by either reset
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
    end else if (dbg_rst_s) begin
      unlocked <= 1'b0;
    end else if (wr_en & in_map & (idx == pcc_pkg::IDX_ACCESS_UNLK)) begin
      unlocked <= pwdata[pcc_pkg::UNLOCK_BIT];
    end
  end

  // --------------------------------------------------------------
  // ratio register: the debugger reset is deliberately ignored here
  // so the running clock does not jump under an emulator
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ratio_control <= pcc_pkg::RATIO_RESET;
    end else if (prot_wr & (idx == pcc_pkg::IDX_PLL_RATIO)) begin
      pll_ratio_control <= pwdata[pcc_pkg::RATIO_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // plain protected storage; debugger reset returns them to zero
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_prescale <= pcc_pkg::REG_RESET;
      ls_prescale <= pcc_pkg::REG_RESET;
      clk_gate    <= pcc_pkg::REG_RESET;
      low_power_0 <= pcc_pkg::REG_RESET;
      low_power_1 <= pcc_pkg::REG_RESET;
      wd_key      <= pcc_pkg::REG_RESET;
      wd_control  <= pcc_pkg::REG_RESET;
    end else if (dbg_rst_s) begin
      hs_prescale <= pcc_pkg::REG_RESET;
      ls_prescale <= pcc_pkg::REG_RESET;
      clk_gate    <= pcc_pkg::REG_RESET;
      low_power_0 <= pcc_pkg::REG_RESET;
      low_power_1 <= pcc_pkg::REG_RESET;
      wd_key      <= pcc_pkg::REG_RESET;
      wd_control  <= pcc_pkg::REG_RESET;
    end else if (prot_wr) begin
      case (idx)
        pcc_pkg::IDX_HS_PRESCALE: hs_prescale <= pwdata[15:0];
        pcc_pkg::IDX_LS_PRESCALE: ls_prescale <= pwdata[15:0];
        pcc_pkg::IDX_CLK_GATE:    clk_gate    <= pwdata[15:0];
        pcc_pkg::IDX_LOW_POWER_0: low_power_0 <= pwdata[15:0];
        pcc_pkg::IDX_LOW_POWER_1: low_power_1 <= pwdata[15:0];
        pcc_pkg::IDX_WD_KEY:      wd_key      <= pwdata[15:0];
        pcc_pkg::IDX_WD_CONTROL:  wd_control  <= pwdata[15:0];
        default: ;  // status and count handled elsewhere
      endcase
    end
  end

  // --------------------------------------------------------------
  // strap capture: waits for the synchroniser to fill after release
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt <= 2'h0;
      pll_off  <= 1'b0;
    end else if (boot_cnt != pcc_pkg::STRAP_DONE) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == pcc_pkg::STRAP_CATCH) begin
        pll_off <= ~strap_s;
      end
    end
  end

  // --------------------------------------------------------------
  // pll settle counter, counts input clock rises after a ratio write
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt   <= '0;
      pll_stable <= 1'b1;
    end else if (prot_wr & (idx == pcc_pkg::IDX_PLL_RATIO)) begin
      lock_cnt   <= '0;
      pll_stable <= (pwdata[pcc_pkg::RATIO_W-1:0] == pcc_pkg::RATIO_BYPASS);
    end else if (!pll_stable & clk_rise) begin
      if (lock_cnt == pcc_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
        pll_stable <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // clock path selection; reserved codes fall back to bypass
  // --------------------------------------------------------------
  assign ratio_valid = (pll_ratio_control != pcc_pkg::RATIO_BYPASS) &&
                       (pll_ratio_control <= pcc_pkg::RATIO_MAX_VALID);
  assign limp = ~pll_off & ratio_valid & clk_lost;

  // registered so the clock tree sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl.mode   <= pcc_pkg::MODE_BYPASS;
      clk_ctrl.mult   <= pcc_pkg::RATIO_RESET;
      clk_ctrl.div2   <= 1'b1;
      clk_ctrl.pll_on <= 1'b0;
    end else if (pll_off) begin
      clk_ctrl.mode   <= pcc_pkg::MODE_DISABLED;
      clk_ctrl.mult   <= pcc_pkg::RATIO_RESET;
      clk_ctrl.div2   <= 1'b0;
      clk_ctrl.pll_on <= 1'b0;
    end else if (limp) begin
      clk_ctrl.mode   <= pcc_pkg::MODE_LIMP;
      clk_ctrl.mult   <= pll_ratio_control;
      clk_ctrl.div2   <= 1'b1;
      clk_ctrl.pll_on <= 1'b1;
    end else if (ratio_valid) begin
      clk_ctrl.mode   <= pcc_pkg::MODE_ENABLED;
      clk_ctrl.mult   <= pll_ratio_control;
      clk_ctrl.div2   <= 1'b1;
      clk_ctrl.pll_on <= 1'b1;
    end else begin
      clk_ctrl.mode   <= pcc_pkg::MODE_BYPASS;
      clk_ctrl.mult   <= pcc_pkg::RATIO_RESET;
      clk_ctrl.div2   <= 1'b1;
      clk_ctrl.pll_on <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // watchdog count runs on input clock edges and freezes in limp,
  // which is what firmware reads to spot the dead oscillator
  // --------------------------------------------------------------
  assign wd_run = wd_control[pcc_pkg::WD_EN_BIT] & clk_rise & ~limp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_count            <= '0;
      watchdog_wake_event <= 1'b0;
    end else if (dbg_rst_s) begin
      wd_count            <= '0;
      watchdog_wake_event <= 1'b0;
    end else if (prot_wr & (idx == pcc_pkg::IDX_WD_COUNT)) begin
      wd_count            <= pwdata[pcc_pkg::WD_CNT_W-1:0];
      watchdog_wake_event <= 1'b0;
    end else begin
      watchdog_wake_event <= wd_run & (&wd_count);
      if (wd_run) wd_count <= wd_count + 1'b1;
    end
  end

endmodule : pcc_ctrl

// >>> tb/pcc_osc_model.sv
// pcc_osc_model: crystal stand-in that drives the input clock pin.
// assumes run comes from the bench; a stopped crystal holds its level.
`timescale 1ns/1ns
module pcc_osc_model #(
  parameter int HALF_NS = 100  // 5 MHz, well under the sampling limit
) (
  input  wire logic run,         // oscillator running
  output logic      input_clock  // clock to the device pin
);
  // free toggle; with the bench's pclk its edges fall on pclk falling edges
  initial begin
    input_clock = 1'b0;
    forever begin
      #HALF_NS;
      if (run) input_clock = ~input_clock;  // failure: edges stop
    end
  end
endmodule : pcc_osc_model

// >>> tb/pcc_ctrl_sva.sv
// pcc_ctrl_sva: port-level checks of the clock ratio control block.
// assumes it is bound into pcc_ctrl; sees top-level ports only.
`timescale 1ns/1ns
module pcc_ctrl_sva #(
  parameter int LOCK_CYCLES = 8  // pll settle count, as the design
) (
  input wire logic                   pclk,          // system clock
  input wire logic                   presetn,       // external reset
  input wire logic                   psel,          // apb select
  input wire logic                   penable,       // apb access
  input wire logic                   pwrite,        // apb direction
  input wire logic [17:0]            paddr,         // apb address
  input wire logic [31:0]            pwdata,        // apb write data
  input wire logic [31:0]            prdata,        // apb read data
  input wire logic                   pready,        // apb ready
  input wire logic                   debug_reset_n, // debugger reset
  input wire pcc_pkg::pcc_clk_ctrl_t clk_ctrl,      // clock tree ctrl
  input wire logic [15:0]            hs_prescale,   // watched register
  input wire logic                   watchdog_wake_event // count wrap
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic              wr;     // committed write
  logic              unlk;   // shadow of the unlock bit
  logic              wr_rt;  // unlocked ratio write, strap not off
  logic [15:0]       idx;    // word index
  logic [3:0]        rv;     // ratio value written
  pcc_pkg::pcc_mode_t m;     // current mode
  assign idx = paddr[17:2];
  assign rv  = pwdata[3:0];
  assign m   = clk_ctrl.mode;
  assign wr  = psel && penable && pwrite && pready && paddr[1:0] == 2'h0;
  assign wr_rt = wr && unlk && idx == pcc_pkg::IDX_PLL_RATIO &&
                 m != pcc_pkg::MODE_DISABLED;

  // shadow unlock; cleared early on debug reset, so only conservative
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlk <= 1'b0;
    end else if (!debug_reset_n) begin
      unlk <= 1'b0;
    end else if (wr && idx == pcc_pkg::IDX_ACCESS_UNLK) begin
      unlk <= pwdata[0];
    end
  end

  rt_enable_a: assert property (
    wr_rt && rv inside {[4'h1:4'hA]} |-> ##2
    (m == pcc_pkg::MODE_ENABLED && clk_ctrl.mult == $past(rv, 2)))
    else $error("valid ratio did not enable the pll");
  rt_bypass_a: assert property (
    wr_rt && (rv == 4'h0 || rv > 4'hA) |-> ##2
    (m == pcc_pkg::MODE_BYPASS && clk_ctrl.div2))
    else $error("zero or reserved ratio did not bypass");
  lock_hold_a: assert property (
    wr && !unlk && idx == pcc_pkg::IDX_HS_PRESCALE |=> $stable(hs_prescale))
    else $error("locked write changed a register");
  unlock_write_a: assert property (
    wr && unlk && idx == pcc_pkg::IDX_HS_PRESCALE |=>
    hs_prescale == $past(pwdata[15:0])) else $error("unlocked write lost");
  enabled_shape_a: assert property (
    m == pcc_pkg::MODE_ENABLED |-> clk_ctrl.pll_on && clk_ctrl.div2 &&
    clk_ctrl.mult inside {[4'h1:4'hA]}) else $error("bad enabled controls");
  direct_shape_a: assert property (
    m == pcc_pkg::MODE_DISABLED |-> !clk_ctrl.div2 && !clk_ctrl.pll_on)
    else $error("disabled mode not direct");
  limp_entry_a: assert property (
    m == pcc_pkg::MODE_LIMP && $past(m) != pcc_pkg::MODE_LIMP |->
    $past(m) == pcc_pkg::MODE_ENABLED) else $error("limp without pll");
  limp_frozen_a: assert property (
    m == pcc_pkg::MODE_LIMP && $past(m) == pcc_pkg::MODE_LIMP |->
    !watchdog_wake_event) else $error("watchdog moved in limp");
  debug_keep_a: assert property (
    !debug_reset_n && !$past(debug_reset_n) |-> $stable(clk_ctrl))
    else $error("debug reset changed clock ratio");
  read_upper_a: assert property (
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  ratio_on_c: cover property (m == pcc_pkg::MODE_ENABLED);
  limp_c: cover property (m == pcc_pkg::MODE_LIMP);
  debug_c: cover property (!debug_reset_n);
endmodule : pcc_ctrl_sva

bind pcc_ctrl pcc_ctrl_sva #(.LOCK_CYCLES(LOCK_CYCLES)) pcc_ctrl_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .debug_reset_n(debug_reset_n), .clk_ctrl(clk_ctrl),
  .hs_prescale(hs_prescale), .watchdog_wake_event(watchdog_wake_event));

// >>> tb/pcc_ctrl_bench.sv
// pcc_ctrl_bench: apb-driven self-checking bench of pcc_ctrl.
// assumes pcc_osc_model as crystal; settle count shortened to 8.
`timescale 1ns/1ns
module pcc_ctrl_bench;
  logic        pclk, presetn, psel, penable, pwrite, err, osc_run;
  logic        debug_reset_n, pll_disable_pin, input_clock, wake;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic        pready, pslverr;
  logic [15:0] hs, ls, gate, lp0, lp1;
  pcc_pkg::pcc_clk_ctrl_t clk_ctrl;  // watched clock controls
  int          bad_count, tests_run;
  int          wake_n = 0;  // wrap pulses seen on the port

  // count watchdog wrap pulses as the design drives them
  always @(posedge pclk) if (wake === 1'b1) wake_n++;
  logic [15:0] regs [5] = '{pcc_pkg::IDX_HS_PRESCALE,
    pcc_pkg::IDX_LS_PRESCALE, pcc_pkg::IDX_CLK_GATE,
    pcc_pkg::IDX_LOW_POWER_0, pcc_pkg::IDX_LOW_POWER_1};

  pcc_ctrl #(.LOCK_CYCLES(8)) pcc_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_reset_n(debug_reset_n),
    .pll_disable_pin(pll_disable_pin), .input_clock(input_clock),
    .clk_ctrl(clk_ctrl), .hs_prescale(hs), .ls_prescale(ls),
    .clk_gate(gate), .low_power_0(lp0), .low_power_1(lp1),
    .watchdog_wake_event(wake));
  pcc_osc_model pcc_osc_model_i (.run(osc_run), .input_clock(input_clock));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end

  task check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one apb transfer; waits for pready, no assumed latency
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task do_reset(input logic strap);
    presetn <= 1'b0; pll_disable_pin <= strap; osc_run <= 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : do_reset

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; debug_reset_n = 1; pll_disable_pin = 1; osc_run = 1;
    bad_count = 0; tests_run = 0;
    do_reset(1'b1);
    apb(0, pcc_pkg::IDX_PLL_RATIO, 0); check("ratio", rd, 0);
    check("clk_ctrl", {24'h0, clk_ctrl}, 32'h42);
    apb(0, pcc_pkg::IDX_SYS_STATUS, 0); check("status", rd, 1);
    // locked writes must vanish
    apb(1, pcc_pkg::IDX_PLL_RATIO, 5); apb(1, regs[0], 32'h1234);
    apb(0, pcc_pkg::IDX_PLL_RATIO, 0); check("ratio", rd, 0);
    apb(0, regs[0], 0); check("hs", rd, 0);
    apb(1, pcc_pkg::IDX_ACCESS_UNLK, 1);
    for (int i = 0; i < 5; i++) begin
      apb(1, regs[i], 32'hFFFF_A5A0 + i);
      apb(0, regs[i], 0); check("reg", rd, 32'hA5A0 + i);
    end
    check("hs_port", {16'h0, hs}, 32'hA5A0);
    $display("test reset and protection done");
    // watchdog left disabled across every ratio write below
    for (int n = 0; n < 16; n++) begin
      apb(1, pcc_pkg::IDX_PLL_RATIO, 32'hFFFF_FFF0 | n);
      apb(0, pcc_pkg::IDX_PLL_RATIO, 0); check("ratio", rd, n);
      check("mode", {30'h0, clk_ctrl.mode}, (n > 0 && n < 11) ?
            pcc_pkg::MODE_ENABLED : pcc_pkg::MODE_BYPASS);
    end
    apb(1, pcc_pkg::IDX_PLL_RATIO, 5);
    apb(0, pcc_pkg::IDX_SYS_STATUS, 0); check("settle", rd[0], 0);
    repeat (120) @(posedge pclk);
    apb(0, pcc_pkg::IDX_SYS_STATUS, 0); check("settle", rd[0], 1);
    $display("test ratio codes done");
    debug_reset_n <= 1'b0;
    repeat (5) @(posedge pclk);
    debug_reset_n <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, pcc_pkg::IDX_PLL_RATIO, 0); check("ratio", rd, 5);
    apb(0, regs[0], 0); check("hs", rd, 0);
    check("clk_ctrl", {24'h0, clk_ctrl}, 32'h97);
    $display("test debug reset done");
    apb(1, pcc_pkg::IDX_ACCESS_UNLK, 1);
    apb(1, pcc_pkg::IDX_WD_COUNT, 32'hFD);
    apb(1, pcc_pkg::IDX_WD_CONTROL, 1);
    apb(0, pcc_pkg::IDX_WD_COUNT, 0); c0 = rd;
    repeat (40) @(posedge pclk);
    apb(0, pcc_pkg::IDX_WD_COUNT, 0); check("wd_runs", rd != c0, 1);
    check("wake", wake_n, 1);
    osc_run <= 1'b0;
    repeat (100) @(posedge pclk);
    check("mode", clk_ctrl.mode, pcc_pkg::MODE_LIMP);
    apb(0, pcc_pkg::IDX_SYS_STATUS, 0); check("lost", rd[2:1], 3);
    apb(0, pcc_pkg::IDX_WD_COUNT, 0); c0 = rd;
    repeat (50) @(posedge pclk);
    apb(0, pcc_pkg::IDX_WD_COUNT, 0); check("wd_frozen", rd, c0);
    $display("test clock loss done");
    do_reset(1'b0);
    check("mode", clk_ctrl.mode, pcc_pkg::MODE_DISABLED);
    apb(1, pcc_pkg::IDX_ACCESS_UNLK, 1); apb(1, pcc_pkg::IDX_PLL_RATIO, 5);
    repeat (3) @(posedge pclk);
    check("mode", clk_ctrl.mode, pcc_pkg::MODE_DISABLED);
    apb(0, pcc_pkg::IDX_SYS_STATUS, 0); check("strap", rd[3], 1);
    apb(0, 16'h7024, 0); check("slverr", err, 1);
    check("hole", rd, 0);
    $display("test strap and unmapped done");
    report_and_stop();
  end
endmodule : pcc_ctrl_bench
